/* File: opa_consts.svh */
`ifndef OPA_CONSTS_SVH
`define OPA_CONSTS_SVH

// ***************************************************
// Timing
// ***************************************************
`define OPA_CLK_HZ 125000000
`define OPA_LOSS_TIME_S 5
`define OPA_HOLD_TIME_S 3
`define OPA_LOSS_CYC (`OPA_LOSS_TIME_S * `OPA_CLK_HZ)
`define OPA_HOLD_CYC (`OPA_HOLD_TIME_S * `OPA_CLK_HZ)

// ***************************************************
// Register map and fields
// ***************************************************
`define OPA_OFF_CTRL 8'h00
`define OPA_OFF_TERMA 8'h04
`define OPA_OFF_TERMB 8'h08
`define OPA_OFF_VALUE 8'h0c
`define OPA_OFF_STAT 8'h10
`define OPA_CTRL_INIT_LSB 0
`define OPA_CTRL_CONN_LSB 8
`define OPA_CTRL_LOSS_LSB 16
`define OPA_CTRL_BATCH_BIT 20
`define OPA_CTRL_WLOCK_BIT 21
`define OPA_RST_INIT_SEL 8'h01
`define OPA_RST_CONN_SEL 8'h01

// ***************************************************
// Codes
// ***************************************************
`define OPA_FN_LOCK 8'h56
`define OPA_SEL_LAST 8'h00
`define OPA_MON_FIRST 8'h01
`define OPA_MON_LAST 8'h3c
`define OPA_SEL_MENU_BACK_KEY 8'hc9
`define OPA_SEL_MODE_B 8'hca
`define OPA_ACT_TRIP 3'h0
`define OPA_ACT_DECEL_TRIP 3'h1
`define OPA_ACT_IGNORE 3'h2
`define OPA_ACT_COAST 3'h3
`define OPA_ACT_DECEL 3'h4
`define OPA_DISPLAY_MAX 17'h1869f
`define OPA_MINUS 4'hf
`endif

/* File: opa_hold_timer.sv */
`timescale 1ns/100ps
`include "opa_consts.svh"
module opa_hold_timer #(
  parameter int unsigned CYCLES = `OPA_HOLD_CYC,
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  opa_tmr_if.timer tif
);
  import opa_pkg::*;

  if (CYCLES < 1 || WIDTH < 2 || WIDTH > 32 ||
      (WIDTH < 32 && CYCLES >= (64'h1 << WIDTH))) begin : g_chk
    $error("opa_hold_timer: CYCLES does not fit WIDTH");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire [WIDTH-1:0] limit_w = CYCLES[WIDTH-1:0];

  // Saturating count of cycles with run held and no restart
  assign tif.done = count_reg == limit_w;
  assign count_next = tif.clr ? '0 :
                      (tif.run && !tif.done) ? count_reg + 1'b1 :
                      count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : opa_hold_timer

/* File: opa_panel_arb.sv */
`timescale 1ns/100ps
`include "opa_consts.svh"
module opa_panel_arb #(
  parameter int ADDR_W = 8,
  parameter int N_TERM = 7,
  parameter int unsigned LOSS_CYCLES = `OPA_LOSS_CYC,
  parameter int unsigned HOLD_CYCLES = `OPA_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_TERM-1:0] term_in,
  input wire logic key_set,
  input wire logic key_esc,
  input wire logic dial_cw,
  input wire logic dial_ccw,
  input wire logic rem_msg_valid,
  input wire logic confirm_key,
  input wire logic menu_back_key,
  input wire logic rem_up,
  input wire logic rem_down,
  input wire logic stop_done,
  input wire logic batch_rd_req,
  input wire logic batch_wr_req,
  output logic batch_rd_grant,
  output logic batch_rd_deny,
  output logic batch_wr_grant,
  output logic batch_wr_deny,
  output logic remote_connected,
  output logic local_control,
  output logic display_locked,
  output logic [7:0] display_item,
  output opa_pkg::opa_src_t display_source,
  output logic remote_mode_b,
  output logic [19:0] display_digits,
  output logic negative_led,
  output logic [15:0] remote_digits,
  output logic remote_loss_trip,
  output logic decel_stop,
  output logic coast_stop,
  output logic set_out,
  output logic esc_out,
  output logic cw_out,
  output logic ccw_out
);
  import opa_pkg::*;

  if (N_TERM < 1 || N_TERM > 8 || ADDR_W < 5) begin : g_chk
    $error("opa_panel_arb: unsupported N_TERM or ADDR_W");
  end

  // ***************************************************
  // APB decode
  // ***************************************************
  logic [7:0] init_sel_reg;
  logic [7:0] conn_sel_reg;
  logic [2:0] loss_sel_reg;
  logic batch_sel_reg;
  logic wlock_reg;
  logic [17:0] value_reg;
  logic [31:0] prdata_reg;
  logic connected_reg;
  logic esc_local_reg;
  logic esc_done_reg;
  opa_loss_t ls_reg;
  opa_loss_t ls_next;

  wire [7:0] addr_w = 8'(paddr);
  wire hit_ctrl = addr_w == `OPA_OFF_CTRL;
  wire hit_terma = addr_w == `OPA_OFF_TERMA;
  wire hit_termb = addr_w == `OPA_OFF_TERMB;
  wire hit_value = addr_w == `OPA_OFF_VALUE;
  wire hit_stat = addr_w == `OPA_OFF_STAT;
  wire hit_any = (hit_ctrl | hit_terma | hit_termb | hit_value |
                  hit_stat) && (paddr == ADDR_W'(addr_w));
  wire setup_w = psel & ~penable;
  wire access_w = psel & penable;
  wire wr_w = access_w & pwrite & hit_any;

  assign pready = access_w;
  assign pslverr = access_w & ~hit_any;
  assign prdata = prdata_reg;

  // ***************************************************
  // Control register
  // ***************************************************
  wire [7:0] w_init = pwdata[`OPA_CTRL_INIT_LSB +: 8];
  wire [7:0] w_conn = pwdata[`OPA_CTRL_CONN_LSB +: 8];
  wire [2:0] w_loss = pwdata[`OPA_CTRL_LOSS_LSB +: 3];
  wire init_ok = w_init <= `OPA_MON_LAST || w_init == `OPA_SEL_MENU_BACK_KEY ||
                 w_init == `OPA_SEL_MODE_B;
  wire conn_ok = w_conn >= `OPA_MON_FIRST && w_conn <= `OPA_MON_LAST;
  wire loss_ok = w_loss <= `OPA_ACT_DECEL;
  wire wr_ctrl = wr_w & hit_ctrl;
  wire [7:0] init_sel_next = (wr_ctrl & init_ok) ? w_init : init_sel_reg;
  wire [7:0] conn_sel_next = (wr_ctrl & conn_ok) ? w_conn : conn_sel_reg;
  wire [2:0] loss_sel_next = (wr_ctrl & loss_ok) ? w_loss : loss_sel_reg;
  wire batch_sel_next = wr_ctrl ? pwdata[`OPA_CTRL_BATCH_BIT] :
                        batch_sel_reg;
  wire wlock_next = wr_ctrl ? pwdata[`OPA_CTRL_WLOCK_BIT] : wlock_reg;
  wire [17:0] value_next = (wr_w & hit_value) ? pwdata[17:0] : value_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_sel_reg <= `OPA_RST_INIT_SEL;
      conn_sel_reg <= `OPA_RST_CONN_SEL;
      loss_sel_reg <= `OPA_ACT_TRIP;
      batch_sel_reg <= 1'b0;
      wlock_reg <= 1'b0;
      value_reg <= '0;
    end else begin
      init_sel_reg <= init_sel_next;
      conn_sel_reg <= conn_sel_next;
      loss_sel_reg <= loss_sel_next;
      batch_sel_reg <= batch_sel_next;
      wlock_reg <= wlock_next;
      value_reg <= value_next;
    end
  end

  // ***************************************************
  // Terminal functions and display lock
  // ***************************************************
  logic [63:0] term_flat;
  logic [N_TERM-1:0] lock_hit;

  for (genvar i = 0; i < 8; i++) begin : g_term
    if (i < N_TERM) begin : g_used
      logic [7:0] fn_reg;
      wire hit_w = (i < 4) ? hit_terma : hit_termb;
      wire [7:0] fn_next = (wr_w & hit_w) ? pwdata[(i%4)*8 +: 8] : fn_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fn_reg <= 8'h00;
        end else begin
          fn_reg <= fn_next;
        end
      end
      assign term_flat[i*8 +: 8] = fn_reg;
      assign lock_hit[i] = term_in[i] & (fn_reg == `OPA_FN_LOCK);
    end else begin : g_unused
      assign term_flat[i*8 +: 8] = 8'h00;
    end
  end

  wire display_lock_input = |lock_hit;

  // ***************************************************
  // Link timers
  // ***************************************************
  opa_tmr_if loss_if ();
  opa_tmr_if hold_if ();

  assign loss_if.run = connected_reg;
  assign loss_if.clr = rem_msg_valid | ~connected_reg;
  assign hold_if.run = connected_reg & key_esc;
  assign hold_if.clr = ~key_esc | ~connected_reg;

  opa_hold_timer #(.CYCLES(LOSS_CYCLES + 1), .WIDTH(32)) u_loss (
    .pclk(pclk),
    .presetn(presetn),
    .tif(loss_if.timer)
  );

  opa_hold_timer #(.CYCLES(HOLD_CYCLES), .WIDTH(32)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .tif(hold_if.timer)
  );

  // ***************************************************
  // Connection, ownership and loss action
  // ***************************************************
  wire lose_w = connected_reg & loss_if.done & ~rem_msg_valid;
  wire connected_next = rem_msg_valid | (connected_reg & ~lose_w);
  wire hold_rise = hold_if.done & ~esc_done_reg;
  wire esc_local_next = ~connected_next ? 1'b0 :
                        hold_rise ? ~esc_local_reg : esc_local_reg;
  wire remote_owns = connected_reg & ~esc_local_reg;

  always_comb begin
    ls_next = ls_reg;
    if (rem_msg_valid) begin
      ls_next = ls_none;
    end else if (lose_w) begin
      unique case (loss_sel_reg)
        `OPA_ACT_TRIP: ls_next = ls_trip;
        `OPA_ACT_DECEL_TRIP: ls_next = ls_decel_trip;
        `OPA_ACT_COAST: ls_next = ls_coast;
        `OPA_ACT_DECEL: ls_next = ls_decel;
        default: ls_next = ls_none;
      endcase
    end else if (ls_reg == ls_decel_trip && stop_done) begin
      ls_next = ls_trip;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      connected_reg <= 1'b0;
      esc_local_reg <= 1'b0;
      esc_done_reg <= 1'b0;
      ls_reg <= ls_none;
    end else begin
      connected_reg <= connected_next;
      esc_local_reg <= esc_local_next;
      esc_done_reg <= hold_if.done;
      ls_reg <= ls_next;
    end
  end

  assign remote_connected = connected_reg;
  assign local_control = ~remote_owns;
  assign remote_loss_trip = ls_reg == ls_trip;
  assign decel_stop = ls_reg == ls_decel_trip || ls_reg == ls_decel;
  assign coast_stop = ls_reg == ls_coast;

  // ***************************************************
  // Key routing and batch gating
  // ***************************************************
  wire set_next = remote_owns ? confirm_key : key_set;
  wire esc_next = remote_owns ? menu_back_key : key_esc;
  wire cw_next = remote_owns ? rem_up : dial_cw;
  wire ccw_next = remote_owns ? rem_down : dial_ccw;
  wire rd_ok = connected_reg & ~batch_sel_reg;
  wire wr_ok = rd_ok & ~wlock_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_out <= 1'b0;
      esc_out <= 1'b0;
      cw_out <= 1'b0;
      ccw_out <= 1'b0;
      batch_rd_grant <= 1'b0;
      batch_rd_deny <= 1'b0;
      batch_wr_grant <= 1'b0;
      batch_wr_deny <= 1'b0;
    end else begin
      set_out <= set_next;
      esc_out <= esc_next;
      cw_out <= cw_next;
      ccw_out <= ccw_next;
      batch_rd_grant <= batch_rd_req & rd_ok;
      batch_rd_deny <= batch_rd_req & ~rd_ok;
      batch_wr_grant <= batch_wr_req & wr_ok;
      batch_wr_deny <= batch_wr_req & ~wr_ok;
    end
  end

  // ***************************************************
  // Display selection and digits
  // ***************************************************
  function automatic logic [19:0] to_bcd(input logic [16:0] bin);
    logic [19:0] bcd;
    bcd = '0;
    for (int i = 16; i >= 0; i--) begin
      for (int d = 0; d < 5; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], bin[i]};
    end
    return bcd;
  endfunction : to_bcd

  wire use_conn = connected_reg & ~esc_local_reg & ~display_lock_input;
  wire [7:0] sel_w = use_conn ? conn_sel_reg : init_sel_reg;
  wire sel_mon = sel_w >= `OPA_MON_FIRST && sel_w <= `OPA_MON_LAST;
  wire opa_src_t src_next = sel_mon ? src_monitor :
                            (sel_w == `OPA_SEL_MENU_BACK_KEY) ? src_first_function :
                            src_last_set;
  wire [17:0] mag_w = value_reg[17] ? 18'(-value_reg) : value_reg;
  wire [16:0] sat_w = (mag_w > 18'(`OPA_DISPLAY_MAX)) ? `OPA_DISPLAY_MAX :
                      mag_w[16:0];
  wire [19:0] bcd_w = to_bcd(sat_w);
  wire [15:0] rem_next = value_reg[17] ? {`OPA_MINUS, bcd_w[11:0]} :
                         bcd_w[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_item <= `OPA_RST_INIT_SEL;
      display_source <= src_monitor;
      display_locked <= 1'b0;
      remote_mode_b <= 1'b0;
      display_digits <= '0;
      negative_led <= 1'b0;
      remote_digits <= '0;
    end else begin
      display_item <= sel_w;
      display_source <= src_next;
      display_locked <= display_lock_input;
      remote_mode_b <= init_sel_reg == `OPA_SEL_MODE_B;
      display_digits <= bcd_w;
      negative_led <= value_reg[17];
      remote_digits <= rem_next;
    end
  end

  // ***************************************************
  // Read data
  // ***************************************************
  wire [31:0] ctrl_rd = {10'h000, wlock_reg, batch_sel_reg, 1'b0,
                         loss_sel_reg, conn_sel_reg, init_sel_reg};
  wire [31:0] stat_rd = {16'h0000, display_item, 1'b0, 3'(ls_reg),
                         display_lock_input, ls_reg != ls_none,
                         ~remote_owns, connected_reg};
  wire [31:0] rd_w = hit_ctrl ? ctrl_rd :
                     hit_terma ? term_flat[31:0] :
                     hit_termb ? term_flat[63:32] :
                     hit_value ? {{14{value_reg[17]}}, value_reg} :
                     hit_stat ? stat_rd : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_w) begin
      prdata_reg <= (hit_any && !pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOCK_ITEM: assert property (
    display_lock_input |=> display_item == $past(init_sel_reg)
  ) else $error("Locked display left the initial item");
  AST_KEY_BLOCK: assert property (
    (remote_owns && key_set && !confirm_key) |=> !set_out
  ) else $error("Built-in key passed while remote owns");
  AST_CONN_ITEM: assert property (
    use_conn |=> display_item == $past(conn_sel_reg)
  ) else $error("Connected display item wrong");
  AST_LOSS_DROP: assert property (
    lose_w |=> !remote_connected ##0 $stable(display_item) or
    !remote_connected
  ) else $error("Link loss not declared");
  AST_ACT_TRIP: assert property (
    (lose_w && loss_sel_reg == `OPA_ACT_TRIP) |=> remote_loss_trip
  ) else $error("Trip action missing");
  AST_ACT_DECEL: assert property (
    (lose_w && loss_sel_reg == `OPA_ACT_DECEL_TRIP) |=>
    decel_stop && !remote_loss_trip
  ) else $error("Decelerate then trip action wrong");
  AST_BATCH_OFF: assert property (
    (batch_rd_req && batch_sel_reg) |=> batch_rd_deny && !batch_rd_grant
  ) else $error("Batch read granted while disabled");
  AST_WLOCK: assert property (
    (batch_wr_req && batch_rd_req && wlock_reg && rd_ok) |=>
    batch_wr_deny && batch_rd_grant
  ) else $error("Write lock gating wrong");
  AST_ESC_TOGGLE: assert property (
    (hold_rise && connected_next) |=> esc_local_reg != $past(esc_local_reg)
  ) else $error("Long escape hold did not toggle ownership");
  AST_NEG: assert property (
    value_reg[17] |=> negative_led && remote_digits[15:12] == `OPA_MINUS
  ) else $error("Negative value shown wrongly");
  AST_MAP: assert property (
    (remote_owns && rem_up) |=> cw_out
  ) else $error("Remote up key not mapped");
  AST_MENU_BACK_KEY_SRC: assert property (
    (sel_w == `OPA_SEL_MENU_BACK_KEY) |=> display_source == src_first_function
  ) else $error("Function selection decoded wrongly");
  AST_RESUME: assert property (
    rem_msg_valid |=> remote_connected && !remote_loss_trip && !decel_stop
  ) else $error("Message did not restore the link");

  COV_LOCK: cover property (display_lock_input ##1 !display_lock_input);
  COV_LOSS: cover property (lose_w ##1 rem_msg_valid);
  COV_TOGGLE: cover property (hold_rise && connected_reg);
  COV_WR_DENY: cover property (batch_wr_deny && !batch_sel_reg);
endmodule : opa_panel_arb

/* File: opa_pkg.sv */
package opa_pkg;
  typedef enum logic [1:0] {
    src_last_set,
    src_monitor,
    src_first_function
  } opa_src_t;
  typedef enum logic [2:0] {
    ls_none,
    ls_trip,
    ls_decel_trip,
    ls_coast,
    ls_decel
  } opa_loss_t;
endpackage : opa_pkg

/* File: opa_remote_model.sv */
`timescale 1ns/100ps
// ***************************************************
// Remote operator panel model
// ***************************************************
module opa_remote_model #(
  parameter int PERIOD = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic alive,
  input wire logic [3:0] keys,
  output logic rem_msg_valid,
  output logic confirm_key,
  output logic menu_back_key,
  output logic rem_up,
  output logic rem_down
);
  int cnt;
  logic tog;
  // Periodic messages only while the link is up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tog <= 1'b0;
      rem_msg_valid <= 1'b0;
    end else begin
      tog <= ~tog;
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      rem_msg_valid <= alive && (cnt == PERIOD - 1);
    end
  end
  // Keys in set, esc, cw, ccw order; junk when unplugged
  assign {confirm_key, menu_back_key, rem_up, rem_down} =
    alive ? keys : {4{tog}};
endmodule : opa_remote_model

/* File: opa_tmr_if.sv */
`timescale 1ns/100ps
interface opa_tmr_if;
  logic run;
  logic clr;
  logic done;
  modport owner (output run, output clr, input done);
  modport timer (input run, input clr, output done);
endinterface : opa_tmr_if

/* File: operator_panel_arbitration_test.sv */
`timescale 1ns/100ps
`include "opa_consts.svh"
module operator_panel_arbitration_test;
  import opa_pkg::*;
  localparam int LOSS = 50;
  localparam int HOLD = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err;
  logic [6:0] term_in = 7'h00;
  logic [3:0] lk = 4'h0, rk = 4'h0;
  logic alive = 1'b0, stop_done = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
  logic rem_msg_valid, confirm_key, menu_back_key, rem_up, rem_down;
  logic rd_g, rd_d, wr_g, wr_d, remote_connected, local_control;
  logic display_locked, remote_mode_b, negative_led;
  logic [7:0] display_item;
  opa_src_t display_source;
  logic [19:0] display_digits;
  logic [15:0] remote_digits;
  logic loss_trip, decel_stop, coast_stop;
  logic [3:0] kout;
  int n_errors = 0, check_count = 0, since_msg = 0, n;
  logic [2:0] act_exp [5] = '{3'b100, 3'b010, 3'b000, 3'b001, 3'b010};
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h3c, 8'hc9, 8'hca};
  always #4 pclk = ~pclk;
  always @(posedge pclk) since_msg <= rem_msg_valid ? 0 : since_msg + 1;
  opa_remote_model u_opa_remote_model (.pclk(pclk), .presetn(presetn),
    .alive(alive), .keys(rk), .rem_msg_valid(rem_msg_valid),
    .confirm_key(confirm_key), .menu_back_key(menu_back_key),
    .rem_up(rem_up), .rem_down(rem_down));
  opa_panel_arb #(.LOSS_CYCLES(LOSS), .HOLD_CYCLES(HOLD)) u_opa_panel_arb (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in),
    .key_set(lk[3]), .key_esc(lk[2]), .dial_cw(lk[1]), .dial_ccw(lk[0]),
    .rem_msg_valid(rem_msg_valid), .confirm_key(confirm_key),
    .menu_back_key(menu_back_key), .rem_up(rem_up), .rem_down(rem_down),
    .stop_done(stop_done), .batch_rd_req(rd_req), .batch_wr_req(wr_req),
    .batch_rd_grant(rd_g), .batch_rd_deny(rd_d), .batch_wr_grant(wr_g),
    .batch_wr_deny(wr_d), .remote_connected(remote_connected),
    .local_control(local_control), .display_locked(display_locked),
    .display_item(display_item), .display_source(display_source),
    .remote_mode_b(remote_mode_b), .display_digits(display_digits),
    .negative_led(negative_led), .remote_digits(remote_digits),
    .remote_loss_trip(loss_trip), .decel_stop(decel_stop),
    .coast_stop(coast_stop), .set_out(kout[3]), .esc_out(kout[2]),
    .cw_out(kout[1]), .ccw_out(kout[0]));
  // ***************************************************
  // Shared tasks
  // ***************************************************
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function logic [31:0] ctrl(input logic [7:0] ini, input logic [7:0] conn,
                             input logic [2:0] loss, input logic b, l);
    return {10'h0, l, b, 1'b0, loss, conn, ini};
  endfunction : ctrl
  task settle;
    repeat (3) @(negedge pclk);
  endtask : settle
  task press(input logic [3:0] l, input logic [3:0] r, input logic [3:0] e);
    @(posedge pclk);
    lk <= l;
    rk <= r;
    settle();
    chk(kout, e);
    @(posedge pclk);
    lk <= 4'h0;
    rk <= 4'h0;
  endtask : press
  task hold_esc(input int c);
    @(posedge pclk);
    lk <= 4'h4;
    repeat (c) @(posedge pclk);
    lk <= 4'h0;
    settle();
  endtask : hold_esc
  task link_up;
    @(posedge pclk);
    alive <= 1'b1;
    n = 0;
    while (remote_connected !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 50) n_errors++;
  endtask : link_up
  // ***************************************************
  // Tests
  // ***************************************************
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(display_item, 8'h01);
    chk(display_source, src_monitor);
    apb(1'b0, `OPA_OFF_CTRL, 32'h0);
    chk(q, 32'h0000_0101);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, q}, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) press(4'h8 >> i, 4'h0, 4'h8 >> i);
    link_up();
    chk(local_control, 1'b0);
    press(4'hf, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++) press(4'h0, 4'h8 >> i, 4'h8 >> i);
    apb(1'b1, `OPA_OFF_CTRL, ctrl(8'h01, 8'h3c, 3'h0, 1'b0, 1'b0));
    apb(1'b1, `OPA_OFF_CTRL, ctrl(8'h01, 8'h3d, 3'h0, 1'b0, 1'b0));
    settle();
    chk(display_item, 8'h3c);
    chk(display_source, src_monitor);
    apb(1'b1, `OPA_OFF_TERMB, 32'h0055_0000);
    apb(1'b1, `OPA_OFF_TERMA, 32'h0056_0000);
    @(posedge pclk);
    term_in <= 7'h40;
    settle();
    chk(display_locked, 1'b0);
    @(posedge pclk);
    term_in <= 7'h04;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `OPA_OFF_CTRL, ctrl(codes[i], 8'h3c, 3'h0, 1'b0, 1'b0));
      settle();
      chk(display_locked, 1'b1);
      chk(remote_mode_b, codes[i] == 8'hca);
      if (i == 1 || i == 2) chk(display_item, codes[i]);
      chk(display_source, i == 3 ? src_first_function :
          (i == 1 || i == 2) ? src_monitor : src_last_set);
    end
    @(posedge pclk);
    term_in <= 7'h00;
    settle();
    chk(display_item, 8'h3c);
    apb(1'b1, `OPA_OFF_VALUE, 32'h0003_ff85);
    settle();
    chk({display_digits, negative_led, remote_digits},
        {20'h00123, 1'b1, 16'hf123});
    apb(1'b0, `OPA_OFF_VALUE, 32'h0);
    chk(q, 32'hffff_ff85);
    apb(1'b1, `OPA_OFF_VALUE, 32'h0000_03db);
    settle();
    chk({display_digits, negative_led, remote_digits},
        {20'h00987, 1'b0, 16'h0987});
    hold_esc(HOLD - 8);
    chk(local_control, 1'b0);
    hold_esc(HOLD + 4);
    chk(local_control, 1'b1);
    press(4'h8, 4'h2, 4'h8);
    hold_esc(HOLD + 4);
    chk(local_control, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OPA_OFF_CTRL, ctrl(8'h01, 8'h3c, 3'h0, i[0], i[1]));
      @(posedge pclk);
      rd_req <= 1'b1;
      wr_req <= 1'b1;
      @(posedge pclk);
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      @(negedge pclk);
      chk({rd_g, rd_d}, i[0] ? 2'b01 : 2'b10);
      chk({wr_g, wr_d}, (i == 0) ? 2'b10 : 2'b01);
    end
    for (int a = 0; a < 5; a++) begin
      apb(1'b1, `OPA_OFF_CTRL, ctrl(8'h01, 8'h3c, a[2:0], 1'b0, 1'b0));
      @(posedge pclk);
      alive <= 1'b0;
      n = 0;
      while (remote_connected === 1'b1 && n < 200) begin
        @(negedge pclk);
        n++;
      end
      chk(since_msg > LOSS && since_msg <= LOSS + 2, 1'b1);
      settle();
      chk({loss_trip, decel_stop, coast_stop}, act_exp[a]);
      if (a == 1) begin
        @(posedge pclk);
        stop_done <= 1'b1;
        settle();
        chk({loss_trip, decel_stop, coast_stop}, 3'b100);
        @(posedge pclk);
        stop_done <= 1'b0;
      end
      link_up();
      settle();
      chk({remote_connected, loss_trip, decel_stop, coast_stop}, 4'h8);
    end
    close_out();
  end
endmodule : operator_panel_arbitration_test
